// file: hw/encoder_transmit_sequencer.sv
// Transmit sequencer: word framing, blanking, time-out, delayed advance, LED and Wishbone registers
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "encoder_seq_cfg.svh"
module encoder_transmit_sequencer #(
    parameter int TICK_CYCLES = `TICK_CYCLES, // Clock cycles per 100 us base tick
    parameter int SHUTOFF_TIMEOUT_MS = `SHUTOFF_TIMEOUT_MS, // Auto-shutoff period
    parameter int SEED_WAIT_QUICK_MS = `DELAYED_SEED_WAIT_MS, // Seed wait with quick learning
    parameter int SEED_WAIT_SLOW_MS = `SEED_WAIT_SLOW_MS // Seed wait without quick learning
) (
    input wire logic clk, // 250 MHz clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [`BUTTON_COUNT-1:0] buttonPin, // Raw button pins, active high
    input wire logic lowVoltagePin, // Supply below trip point, asynchronous
    input wire logic dataBit, // Data level for the current time element
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write enable
    input wire logic [7:0] adr_i, // Wishbone byte address
    input wire logic [3:0] sel_i, // Wishbone byte selects
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    output logic dataOut, // DATA pin to transmitter
    output logic rfEnable, // RF enable output pin
    output logic ledN, // LED pin, active low
    output logic teStrobe, // Pulse at each data time element boundary
    output logic seedRequest, // Pulse asking the word builder for a seed word
    output logic [15:0] syncCount // Stored synchronisation counter
);
    import encoder_seq_pkg::*;

    generate
        if (TICK_CYCLES < 2 || TICK_CYCLES > 65535 || SHUTOFF_TIMEOUT_MS < 100 || SHUTOFF_TIMEOUT_MS > 32767
            || SEED_WAIT_QUICK_MS < 1 || SEED_WAIT_SLOW_MS >= SHUTOFF_TIMEOUT_MS) begin : g_bad
            $error("Unsupported timing parameters");
        end
    endgenerate

    seqState_t state_q, state_d;
    logic [15:0] preCnt_q;
    logic [3:0] tickMs_q;
    logic tick, msTick;
    logic [`BUTTON_COUNT-1:0] btn, btnPrev_q;
    logic active, press, activation;
    logic lvMeta_q, lowV_q;
    logic [10:0] ctrl_q;
    logic [15:0] sync_q, syncInc;
    logic [6:0] delayMs_q;
    logic [14:0] toMs_q;
    logic timerRun, toElapsed;
    logic [2:0] teCnt_q, teLast;
    logic [1:0] teShift, seg_q, tally_q;
    logic [9:0] segPos_q, segLen, ledMs_q;
    logic [7:0] wordIdx_q, minWords;
    logic teEdge, wordEnd, blanked, wordOn, ledLowNow, qlStop, lvl, rfOn;
    logic seedOff_q, seedWrap_q, seedAvail, seedReq_q;
    logic dataOut_q, rfEnable_q, ledN_q, ack_q;
    logic [31:0] dat_q;
    logic wbHit, wbWr;
    logic [14:0] seedWait;
    logic [7:0] syncLowSum;

    wire minFour = ctrl_q[`CTRL_MIN4];
    wire blankOn = ctrl_q[`CTRL_BLANK];
    wire [1:0] baud = ctrl_q[`CTRL_BAUD_HI:`CTRL_BAUD_LO];
    wire delayed_counter_advance = ctrl_q[`CTRL_DELAYED_COUNTER_ADVANCE];
    wire pllFsk = ctrl_q[`CTRL_FSK];
    wire longPre = ctrl_q[`CTRL_LONG_PREAMBLE_ENABLE];
    wire ql = ctrl_q[`CTRL_QL];
    wire tmpSeed = ctrl_q[`CTRL_TMPSEED];
    wire manch = ctrl_q[`CTRL_MANCH];
    wire rfPin = ctrl_q[`CTRL_RFPIN];

    // Base tick of 100 us and a millisecond tick derived from it
    assign tick = preCnt_q == 16'(TICK_CYCLES - 1);
    assign msTick = tick && tickMs_q == 4'(`TICKS_PER_MS - 1);
    always_ff @(posedge clk) begin
        if (!resetn || tick) begin
            preCnt_q <= 16'h0000;
        end else begin
            preCnt_q <= preCnt_q + 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn || msTick) begin
            tickMs_q <= 4'h0;
        end else if (tick) begin
            tickMs_q <= tickMs_q + 4'h1;
        end
    end

    press_debounce #(
        .WIDTH(`BUTTON_COUNT),
        .DEBOUNCE_MS(`PRESS_DEBOUNCE_MS)
    ) u_debounce (
        .clk(clk),
        .resetn(resetn),
        .msTick(msTick),
        .pinIn(buttonPin),
        .level(btn)
    );

    always_ff @(posedge clk) begin
        lvMeta_q <= resetn && lowVoltagePin;
        lowV_q <= resetn && lvMeta_q;
        btnPrev_q <= resetn ? btn : '0;
    end
    assign active = |btn;
    assign press = |(btn & ~btnPrev_q);
    assign activation = press && (state_q == ST_IDLE || state_q == ST_HOLD);

    // Wishbone slave: one wait state, unmapped reads return zero
    assign wbHit = cyc_i && stb_i && !ack_q;
    assign wbWr = wbHit && we_i;
    always_ff @(posedge clk) begin
        ack_q <= resetn && wbHit;
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dat_q <= 32'h00000000;
        end else if (wbHit && !we_i) begin
            unique case (adr_i)
                `REG_CTRL: dat_q <= {21'h000000, ctrl_q};
                `REG_STATUS: dat_q <= {wordIdx_q, 14'h0000, tally_q, seedWrap_q, seedOff_q, lowV_q, state_q};
                `REG_SYNC: dat_q <= {16'h0000, sync_q};
                default: dat_q <= 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q <= `CTRL_RESET;
        end else if (wbWr && adr_i == `REG_CTRL) begin
            if (sel_i[0]) begin
                ctrl_q[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                ctrl_q[10:8] <= dat_i[10:8];
            end
        end
    end

    always_comb begin
        unique case (baud)
            2'h0: teShift = manch ? 2'h3 : 2'h2;
            2'h1: teShift = manch ? 2'h2 : 2'h1;
            default: teShift = manch ? 2'h1 : 2'h0;
        endcase
        teLast = 3'((4'h1 << teShift) - 4'h1);
    end

    always_comb begin
        unique case (seg_q)
            2'h0: segLen = (longPre && wordIdx_q == 8'h00) ? 10'(`LONG_PREAMBLE_TICKS >> teShift)
                                                           : 10'(`PREAMBLE_TE);
            2'h1: segLen = manch ? 10'(`HEADER_TE_MAN) : 10'(`HEADER_TE_PWM);
            2'h2: segLen = manch ? 10'(`DATA_TE_MAN) : 10'(`DATA_TE_PWM);
            default: segLen = manch ? 10'(`GUARD_TE_MAN) : 10'(`GUARD_TE_PWM);
        endcase
    end
    assign teEdge = state_q == ST_SEND && tick && teCnt_q == teLast;
    assign wordEnd = teEdge && seg_q == 2'h3 && segPos_q == segLen - 10'h001;
    assign teStrobe = teEdge && seg_q == 2'h2;

    // word position clears when a transmission is not in progress
    always_ff @(posedge clk) begin
        if (!resetn || state_q != ST_SEND) begin
            teCnt_q <= 3'h0;
            seg_q <= 2'h0;
            segPos_q <= 10'h000;
            wordIdx_q <= 8'h00;
        end else if (tick) begin
            teCnt_q <= teEdge ? 3'h0 : teCnt_q + 3'h1;
            if (teEdge && segPos_q == segLen - 10'h001) begin
                segPos_q <= 10'h000;
                seg_q <= seg_q + 2'h1;
                if (seg_q == 2'h3 && wordIdx_q != 8'hFF) begin
                    wordIdx_q <= wordIdx_q + 8'h01;
                end
            end else if (teEdge) begin
                segPos_q <= segPos_q + 10'h001;
            end
        end
    end

    // blanking pattern; code 00b never blanks
    assign blanked = blankOn && baud != 2'h0 && (baud == 2'h3 ? wordIdx_q[1:0] != 2'h0 : wordIdx_q[0]);
    assign wordOn = state_q == ST_SEND && !blanked;

    // Timer runs from activation through the powered wait
    assign timerRun = state_q == ST_DELAY || state_q == ST_SEND || state_q == ST_HOLD;
    assign toElapsed = timerRun && msTick && toMs_q == 15'(SHUTOFF_TIMEOUT_MS - 1);
    // restart timer on an activation press, from idle or hold
    always_ff @(posedge clk) begin
        if (!resetn || activation) begin
            toMs_q <= 15'h0000;
        end else if (timerRun && msTick && toMs_q != 15'h7FFF) begin
            toMs_q <= toMs_q + 15'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn || state_q != ST_DELAY) begin
            delayMs_q <= 7'h00;
        end else if (msTick) begin
            delayMs_q <= delayMs_q + 7'h01;
        end
    end

    // LED: off phase first, then a periodic or single low pulse
    always_ff @(posedge clk) begin
        if (!resetn || state_q != ST_SEND) begin
            ledMs_q <= 10'h000;
        end else if (msTick) begin
            if (!lowV_q && ledMs_q == 10'(`INDICATOR_OFF_TIME_MS + `INDICATOR_ON_TIME_MS - 1)) begin
                ledMs_q <= 10'h000;
            end else if (ledMs_q != 10'h3FF) begin
                ledMs_q <= ledMs_q + 10'h001;
            end
        end
    end
    assign ledLowNow = state_q == ST_SEND && ledMs_q >= 10'(`INDICATOR_OFF_TIME_MS)
        && (!lowV_q || ledMs_q < 10'(`INDICATOR_OFF_TIME_MS + `INDICATOR_LOW_BATT_TIME_MS));
    assign qlStop = ql && lowV_q && ledLowNow;

    assign minWords = minFour ? `MIN_WORDS_FOUR : 8'h01;
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (press) begin
                    state_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (msTick && delayMs_q == 7'(`TRANSMIT_DELAY_MS - 1)) begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (toElapsed && active) begin
                    state_d = ST_STUCK;
                // words end on a boundary after the minimum, or at once on qlStop
                end else if (qlStop || (wordEnd && !active && wordIdx_q + 8'h01 >= minWords)) begin
                    // with delayed advance stay powered until the period ends, else go idle
                    state_d = delayed_counter_advance ? ST_HOLD : ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (press) begin
                    state_d = ST_DELAY;
                end else if (toElapsed) begin
                    state_d = ST_IDLE;
                end
            end
            ST_STUCK: begin
                if (!active) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // one per activation, twelve when the period elapses with delayed advance
    always_comb begin
        if (activation) begin
            syncInc = 16'h0001;
        end else if (toElapsed && delayed_counter_advance) begin
            syncInc = `DELAYED_ADVANCE;
        end else begin
            syncInc = 16'h0000;
        end
        syncLowSum = {1'b0, sync_q[6:0]} + syncInc[7:0];
    end
    // Hardware increments win over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync_q <= `SYNC_RESET;
        end else if (syncInc != 16'h0000) begin
            sync_q <= sync_q + syncInc;
        end else if (wbWr && adr_i == `REG_SYNC) begin
            if (sel_i[0]) begin
                sync_q[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                sync_q[15:8] <= dat_i[15:8];
            end
        end
    end
    assign syncCount = sync_q;

    // tally clears only on the return to idle
    always_ff @(posedge clk) begin
        if (!resetn || (state_q != ST_IDLE && state_d == ST_IDLE)) begin
            tally_q <= 2'h0;
        end else if (press && tally_q != 2'h3) begin
            tally_q <= tally_q + 2'h1;
        end
    end

    // limited seed ends at low seven bit wrap
    always_ff @(posedge clk) begin
        if (!resetn) begin
            seedWrap_q <= 1'b0;
        end else if (syncInc != 16'h0000 && syncLowSum[7]) begin
            seedWrap_q <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            seedOff_q <= 1'b0;
        end else if (ql && tmpSeed && press && tally_q == `SEED_KILL_PRESSES - 2'h1) begin
            seedOff_q <= 1'b1;
        end
    end
    assign seedAvail = !seedOff_q && !(tmpSeed && seedWrap_q);
    assign seedWait = ql ? 15'(SEED_WAIT_QUICK_MS) : 15'(SEED_WAIT_SLOW_MS);
    always_ff @(posedge clk) begin
        seedReq_q <= resetn && state_q == ST_SEND && active && seedAvail && msTick
            && toMs_q == seedWait - 15'h0001;
    end

    // RF enable: ASK gates per sent word, FSK holds through the transmission
    always_comb begin
        lvl = 1'b0;
        if (wordOn && seg_q == 2'h0) begin
            lvl = !segPos_q[0];
        end else if (wordOn && seg_q == 2'h2) begin
            lvl = dataBit;
        end
        // quick learning: modulation off while LED is low
        if (ql && ledLowNow) begin
            lvl = pllFsk;
        end
        rfOn = rfPin && (pllFsk ? state_q == ST_SEND : wordOn) && !(ql && pllFsk && ledLowNow);
    end
    always_ff @(posedge clk) begin
        dataOut_q <= resetn && lvl;
        rfEnable_q <= resetn && rfOn;
        ledN_q <= !resetn || !ledLowNow;
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign dataOut = dataOut_q;
    assign rfEnable = rfEnable_q;
    assign ledN = ledN_q;
    assign seedRequest = seedReq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence midWordRelease;
        state_q == ST_SEND && !active && !wordEnd && !qlStop && !toElapsed;
    endsequence
    sequence holdPress;
        state_q == ST_HOLD && press;
    endsequence

    chk_word_complete: assert property (midWordRelease |=> state_q == ST_SEND)
        else $error("Transmission left mid-word");
    chk_min_words: assert property (state_q == ST_SEND && state_d != ST_SEND && !toElapsed && !qlStop
        |-> wordIdx_q + 8'h01 >= minWords)
        else $error("Fewer words than the minimum");
    chk_stuck_silent: assert property (state_q == ST_STUCK ##1 state_q == ST_STUCK
        |-> !dataOut_q && !rfEnable_q)
        else $error("Output active in time-out");
    chk_blank_pair: assert property (state_q == ST_SEND && blankOn && (baud == 2'h1 || baud == 2'h2)
        && wordIdx_q[0] |-> !wordOn ##1 (!dataOut_q || $past(ql && pllFsk && ledLowNow)))
        else $error("Odd word not blanked");
    chk_blank_quarter: assert property (state_q == ST_SEND && blankOn && baud == 2'h3
        && wordIdx_q[1:0] != 2'h0 |-> !wordOn ##1 (!dataOut_q || $past(ql && pllFsk && ledLowNow)))
        else $error("Quarter blanking broken");
    chk_delayed_adv: assert property (toElapsed && delayed_counter_advance && !activation
        |=> sync_q == $past(sync_q) + `DELAYED_ADVANCE)
        else $error("Delayed advance not applied");
    chk_hold_restart: assert property (holdPress
        |=> toMs_q == 15'h0000 && sync_q == $past(sync_q) + 16'h0001 ##1 state_q == ST_DELAY)
        else $error("Restart in hold wrong");
    chk_tally_keep: assert property (state_q == ST_HOLD && state_d == ST_HOLD |=> tally_q >= $past(tally_q))
        else $error("Tally cleared early");
    chk_ql_ask: assert property (ql && !pllFsk && ledLowNow ##1 $stable(ctrl_q) |-> !dataOut_q)
        else $error("DATA not low under LED");
    chk_first_word: assert property (state_q == ST_SEND && wordIdx_q == 8'h00 |-> !blanked)
        else $error("First word blanked");
    chk_start_delay: assert property ($rose(state_q == ST_SEND) |-> $past(state_q) == ST_DELAY
        && $past(delayMs_q) == 7'(`TRANSMIT_DELAY_MS - 1))
        else $error("Transmit delay wrong");
endmodule // encoder_transmit_sequencer

// file: inc/encoder_seq_cfg.svh
// Timing, register map and field layout of the encoder transmit sequencer
// What this block does
// - A started code word completes unless the time-out or the quick learning low battery stop cuts it; a held button keeps sending whole words.
// - A momentary press gives one complete word, or four with the option.
// - A button held for the shutoff time-out stops all transmission.
// - Baud select sets the time element; code 00b sends every word.
// - Blanking with baud 01b or 10b sends every second word only.
// - Blanking with baud 11b sends one word in four.
// - Delayed advance adds 12 to the counter after the time-out period.
// - So the next activation shows the counter 13 above the last.
// - Released early: stop sending, stay powered, add 12 at period end.
// - A new press while waiting restarts the timer and adds one only.
// - With delayed advance the press tally clears only after the period.
// - RF enable output covers each sent word in ASK, the whole transmission in FSK; setup select picks ASK or FSK.
// - Good battery: LED driven low 32 ms every 512 ms while sending.
// - Low battery: LED driven low once for 200 ms.
// - Long preamble stretches the first word's preamble to 64 ms square wave.
// - Quick learning shortens the wait before a delayed seed to 3 s.
// - Quick learning with ASK setup holds DATA low while LED is low.
// - Quick learning with FSK: DATA high, RF enable low while LED low.
// - Quick learning and low battery: transmit only until the LED lights.
// - Quick learning with temporary seed: a press sequence disables seed for good.
// - A press counts only after a 20 ms debounce.
// - Transmission starts 30 ms after the press is detected.
// - Limited seed stays available until counter low seven bits wrap.
`ifndef ENCODER_SEQ_CFG_SVH
`define ENCODER_SEQ_CFG_SVH
`define CLOCK_MHZ 250
`define BASE_TICK_US 100
`define TICK_CYCLES (`BASE_TICK_US * `CLOCK_MHZ)
`define TICKS_PER_MS (1000 / `BASE_TICK_US)
`define SHUTOFF_TIMEOUT_MS 20000
`define TRANSMIT_DELAY_MS 30
`define PRESS_DEBOUNCE_MS 20
`define LONG_PREAMBLE_TIME_MS 64
`define LONG_PREAMBLE_TICKS (`LONG_PREAMBLE_TIME_MS * `TICKS_PER_MS)
`define INDICATOR_ON_TIME_MS 32
`define INDICATOR_OFF_TIME_MS 480
`define INDICATOR_LOW_BATT_TIME_MS 200
`define DELAYED_SEED_WAIT_MS 3000
`define SEED_WAIT_SLOW_MS 6000
`define PREAMBLE_TE 31
`define HEADER_TE_PWM 10
`define HEADER_TE_MAN 4
`define DATA_TE_PWM 207
`define DATA_TE_MAN 142
`define GUARD_TE_PWM 46
`define GUARD_TE_MAN 31
`define DELAYED_ADVANCE 16'h000C
`define SEED_KILL_PRESSES 2'h3
`define MIN_WORDS_FOUR 8'h04
`define BUTTON_COUNT 3
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SYNC 8'h08
`define CTRL_RESET 11'h000
`define SYNC_RESET 16'h0000
`define CTRL_MIN4 0
`define CTRL_BLANK 1
`define CTRL_BAUD_LO 2
`define CTRL_BAUD_HI 3
`define CTRL_DELAYED_COUNTER_ADVANCE 4
`define CTRL_FSK 5
`define CTRL_LONG_PREAMBLE_ENABLE 6
`define CTRL_QL 7
`define CTRL_TMPSEED 8
`define CTRL_MANCH 9
`define CTRL_RFPIN 10
`endif

// file: inc/encoder_seq_pkg.sv
// Types shared by the encoder transmit sequencer
package encoder_seq_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DELAY = 5'h02,
        ST_SEND = 5'h04,
        ST_HOLD = 5'h08,
        ST_STUCK = 5'h10
    } seqState_t;
endpackage

// file: hw/press_debounce.sv
// Button synchroniser and debounce filter
`timescale 1ns/1ps
module press_debounce #(
    parameter int WIDTH = 3, // Number of button pins
    parameter int DEBOUNCE_MS = 20 // Stable time before a level is accepted
) (
    input wire logic clk, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic msTick, // One-cycle pulse each millisecond
    input wire logic [WIDTH-1:0] pinIn, // Raw button pins
    output logic [WIDTH-1:0] level // Debounced button levels
);
    generate
        if (DEBOUNCE_MS < 2 || DEBOUNCE_MS > 255) begin : g_bad
            $error("Debounce time out of range");
        end
    endgenerate

    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_btn
            logic meta_q;
            logic sync_q;
            logic level_q;
            logic [7:0] cnt_q;
            always_ff @(posedge clk) begin
                meta_q <= resetn && pinIn[i];
                sync_q <= resetn && meta_q;
            end
            // A change must hold a full debounce time; any bounce restarts the count
            always_ff @(posedge clk) begin
                if (!resetn || sync_q == level_q) begin
                    cnt_q <= 8'h00;
                end else if (msTick) begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    level_q <= 1'b0;
                end else if (msTick && sync_q != level_q && cnt_q == 8'(DEBOUNCE_MS - 1)) begin
                    level_q <= sync_q;
                end
            end
            assign level[i] = level_q;
        end
    endgenerate
endmodule // press_debounce

// file: verif/rf_link_model.sv
// Transmitter model counting data time elements seen and actually radiated
`timescale 1ns/1ps
module rf_link_model (
    input wire logic clk, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic dataOut, // DATA pin
    input wire logic rfEnable, // RF enable pin
    input wire logic teStrobe, // Data time element boundary
    output int dataTes, // Data elements framed
    output int sentTes // Data elements radiated high
);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dataTes <= 0;
            sentTes <= 0;
        end else if (teStrobe === 1'b1) begin
            dataTes <= dataTes + 1;
            if (rfEnable === 1'b1 && dataOut === 1'b1) begin
                sentTes <= sentTes + 1;
            end
        end
    end
endmodule // rf_link_model

// file: verif/tb_top.sv
// Self-checking bench for the encoder transmit sequencer
`timescale 1ns/1ps
`include "encoder_seq_cfg.svh"
module tb_top;
    import encoder_seq_pkg::*;
    typedef struct {logic [31:0] ctrl; int words; int sent;} row_t;
    row_t rows[6] = '{'{32'h40C, 1, 1}, '{32'h40F, 4, 1}, '{32'h407, 4, 2}, '{32'h403, 4, 4}, '{32'h409, 4, 4},
        '{32'h46C, 1, 1}};
    logic clk = 0;
    logic resetn = 0;
    logic [2:0] buttonPin = 3'h0;
    logic lowVolt = 1'b0;
    logic [3:0] sel = 4'hF;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] datO, rd;
    logic ack, dataOut, rfEnable, ledN, teStrobe, seedRequest;
    logic [15:0] syncCount;
    logic [15:0] expSync;
    int fails = 0;
    int checked = 0;
    int dataTes, sentTes, t0, s0;
    int seeds = 0;
    // Seed waits sit after the transmit delay so a held button can reach them
    encoder_transmit_sequencer #(.TICK_CYCLES(4), .SHUTOFF_TIMEOUT_MS(200), .SEED_WAIT_QUICK_MS(40),
        .SEED_WAIT_SLOW_MS(60)) DUT (.clk(clk), .resetn(resetn), .buttonPin(buttonPin), .lowVoltagePin(lowVolt),
        .dataBit(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(datO), .ack_o(ack), .dataOut(dataOut), .rfEnable(rfEnable), .ledN(ledN), .teStrobe(teStrobe),
        .seedRequest(seedRequest), .syncCount(syncCount));
    rf_link_model link (.clk(clk), .resetn(resetn), .dataOut(dataOut), .rfEnable(rfEnable),
        .teStrobe(teStrobe), .dataTes(dataTes), .sentTes(sentTes));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (seedRequest === 1'b1) begin
            seeds <= seeds + 1;
        end
    end
    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask
    // Classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (n = 0; n < 50 && ack !== 1'b1; n++) @(posedge clk);
        if (n == 50) begin
            fails++;
            close_out();
        end
        rd = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic msWait(input int ms);
        repeat (ms * 40) @(posedge clk);
    endtask
    task automatic press(input int ms);
        @(posedge clk);
        buttonPin <= 3'h1;
        msWait(ms);
        buttonPin <= 3'h0;
    endtask
    task automatic waitIdle();
        int n;
        rd = 32'h0;
        for (n = 0; n < 1000 && rd[4:0] !== ST_IDLE; n++) begin
            msWait(1);
            wb(1'b0, `REG_STATUS, 32'h0);
        end
        if (n == 1000) begin
            fails++;
            close_out();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("ledN", 32'h1, ledN);
        chk("sync", 32'h0, syncCount);
        wb(1'b1, `REG_CTRL, 32'h40C);
        wb(1'b0, `REG_CTRL, 32'h0);
        chk("ctrl", 32'h40C, rd);
        wb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", 32'h0, rd);
        sel <= 4'h1;
        wb(1'b1, `REG_CTRL, 32'h0);
        sel <= 4'hF;
        wb(1'b0, `REG_CTRL, 32'h0);
        chk("ctrl sel", 32'h400, rd);
        lowVolt <= 1'b1;
        repeat (3) @(posedge clk);
        wb(1'b0, `REG_STATUS, 32'h0);
        lowVolt <= 1'b0;
        chk("lowV", 32'h1, rd[5]);
        $display("test registers done");
        expSync = 16'h0000;
        foreach (rows[i]) begin
            wb(1'b1, `REG_CTRL, rows[i].ctrl);
            t0 = dataTes;
            s0 = sentTes;
            press(22);
            waitIdle();
            expSync = expSync + 16'h0001;
            chk("words", rows[i].words, (dataTes - t0 + 100) / 207);
            chk("sent", rows[i].sent, (sentTes - s0 + 100) / 207);
            chk("sync", expSync, syncCount);
            $display("test row %0d done", i);
        end
        wb(1'b1, `REG_CTRL, 32'h41C);
        press(22);
        msWait(100);
        chk("sync", expSync + 16'h0001, syncCount);
        press(22);
        msWait(150);
        wb(1'b0, `REG_STATUS, 32'h0);
        chk("hold", ST_HOLD, rd[4:0]);
        chk("tally", 32'h2, rd[9:8]);
        chk("sync", expSync + 16'h0002, syncCount);
        waitIdle();
        chk("tally", 32'h0, rd[9:8]);
        expSync = expSync + 16'h000E;
        chk("sync", expSync, syncCount);
        $display("test delayed advance done");
        wb(1'b1, `REG_CTRL, 32'h40C);
        s0 = seeds;
        @(posedge clk);
        buttonPin <= 3'h1;
        msWait(260);
        chk("seed", s0 + 1, seeds);
        wb(1'b0, `REG_STATUS, 32'h0);
        chk("stuck", ST_STUCK, rd[4:0]);
        t0 = dataTes;
        msWait(5);
        chk("silent", t0, dataTes);
        buttonPin <= 3'h0;
        waitIdle();
        $display("test time-out done");
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        wb(1'b0, `REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        chk("sync reset", 32'h0, syncCount);
        $display("test mid-run reset done");
        close_out();
    end
endmodule // tb_top
